// [logic/pwmsq_playback.sv]
// What this block does
// RULE1: after loops complete, refresh and delay are ignored; last value held.
// RULE2: looped play runs sequence 0, delay 0, sequence 1, delay 1, repeat.
// RULE3: looped play begins at whichever sequence's start task was triggered.
// RULE4: looped play always ends with sequence 1's end delay.
// RULE5: each sequence read from its own pointer and count, paced by its refresh.
// RULE6: sequence 1 chains after 0, pair repeated loop count times automatically.
// RULE7: refresh gives extra periods each value is held; 1 means every second period.
// RULE8: end delay inserts that many periods before the next sequence; zero none.
// RULE9: loop count 1 stops after one sequence 1, raising its end and loops complete.
// RULE10: manual mode: each step task applies next value at next period start.
// RULE11: loop count zero plays the started sequence once, for either sequence.
// RULE12: software programs a nonzero value count for every used sequence.
// RULE13: if the fetch is late, previous compare value repeats without glitch.
// RULE14: each channel routed to its selected pin; disconnected drives no pin.
// RULE15: pin selection applies only while enabled and running.
// RULE16: software sets used pins as outputs at level 0 before enabling.
// RULE17: gpio level sets idle pin whenever stopped or disabled.
// RULE18: software gives each pin to one peripheral only.
// RULE19: stop halts at end of running period, raises stopped, releases pins.
// RULE20: completed sequence 1 plays counted; loops complete raised exactly once.
`timescale 1ns/1ns
`default_nettype none
module pwmsq_playback #(
  parameter int NCH  = 4,
  parameter int NPIN = 32
) (
  input  wire logic            MCLK_IN,
  input  wire logic            RESET_IN,
  input  wire logic [11:0]     AVS_ADDRESS_IN,
  input  wire logic            AVS_READ_IN,
  input  wire logic            AVS_WRITE_IN,
  input  wire logic [31:0]     AVS_WRITEDATA_IN,
  input  wire logic [3:0]      AVS_BYTEENABLE_IN,
  output logic      [31:0]     AVS_READDATA_OUT,
  output logic                 AVS_WAITREQUEST_OUT,
  output logic                 RAM_REQ_OUT,
  output logic      [31:0]     RAM_ADDR_OUT,
  input  wire logic            RAM_ACK_IN,
  input  wire logic [15:0]     RAM_DATA_IN,
  output logic      [NPIN-1:0] PIN_OUT,
  output logic      [NPIN-1:0] PIN_OE_OUT,
  output logic                 STOPPED_EVENT_OUT,
  output logic      [1:0]      SEQUENCE_BEGUN_EVENT_OUT,
  output logic      [1:0]      SEQUENCE_END_EVENT_OUT,
  output logic                 PERIOD_END_EVENT_OUT,
  output logic                 LOOPS_COMPLETE_EVENT_OUT
);
  typedef struct packed {
    pwmsq_pkg::pwmsq_state_e           st;
    logic                              seq;
    logic [14:0]                       idx;
    logic [23:0]                       rcnt;
    logic [23:0]                       dcnt;
    logic [15:0]                       loops;
    logic [15:0]                       cmp;
    logic [15:0]                       nxt;
    logic                              nxt_vld;
    logic                              req;
    logic [31:0]                       addr;
    logic                              disc;
    logic                              stop_pend;
    logic                              step_pend;
    logic                              run;
    logic                              restart;
    logic [pwmsq_pkg::NUM_EV-1:0]      ev;
    logic [pwmsq_pkg::NUM_EV-1:0]      evs;
    logic                              wreq;
    logic [31:0]                       rdata;
    logic                              enable;
    logic [14:0]                       top;
    logic                              manual;
    logic [15:0]                       loopcnt;
    logic [1:0][31:0]                  ptr;
    logic [1:0][14:0]                  cnt;
    logic [1:0][23:0]                  refr;
    logic [1:0][23:0]                  dly;
    logic [NCH-1:0][31:0]              psel;
  } pwmsq_main_s;

  pwmsq_main_s q;
  pwmsq_main_s d;
  logic [11:0] a;
  logic [31:0] wd;
  logic        wr;
  logic        stop_t;
  logic        step_t;
  logic [1:0]  start_t;
  logic        start_any;
  logic        pe_w;
  logic [14:0] cnt_w;
  logic        lastv;
  logic        nlast;
  logic        want;
  logic [14:0] fidx;
  logic        adv;
  logic        fin;
  logic        go;
  logic        stop_now;
  logic [31:0] rd_word;

  assign a         = AVS_ADDRESS_IN;
  assign wd        = AVS_WRITEDATA_IN;
  // a write commits at the edge where waitrequest is seen low
  assign wr        = AVS_WRITE_IN && !q.wreq && (AVS_BYTEENABLE_IN == 4'hf);
  assign stop_t    = wr && (a == pwmsq_pkg::OFS_STOP) && wd[0];
  assign step_t    = wr && (a == pwmsq_pkg::OFS_STEP) && wd[0];
  assign start_t   = {wr && (a == pwmsq_pkg::OFS_START1) && wd[0],
                      wr && (a == pwmsq_pkg::OFS_START0) && wd[0]};
  assign start_any = |start_t;
  assign lastv     = (q.idx == q.cnt[q.seq] - 15'h0001);
  assign nlast     = (q.idx + 15'h0001 == q.cnt[q.seq] - 15'h0001);
  assign want      = (q.st == pwmsq_pkg::ST_LOAD) || (q.st == pwmsq_pkg::ST_PLAY && !lastv);
  assign fidx      = (q.st == pwmsq_pkg::ST_LOAD) ? 15'h0000 : q.idx + 15'h0001;
  assign adv       = q.manual ? q.step_pend : (q.rcnt == 24'h000000);

  always_comb
  begin
    rd_word = '0;
    case (a)
      pwmsq_pkg::OFS_ENABLE:  rd_word[0] = q.enable;
      pwmsq_pkg::OFS_TOP:     rd_word[14:0] = q.top;
      pwmsq_pkg::OFS_DECODER: rd_word[pwmsq_pkg::DEC_MANUAL_BIT] = q.manual;
      pwmsq_pkg::OFS_LOOP:    rd_word[15:0] = q.loopcnt;
      pwmsq_pkg::OFS_STATUS:  rd_word = {1'b0, q.idx, q.loops[7:0], 2'b00, q.run, q.seq,
                                         q.stop_pend, q.st};
      default: ;
    endcase
    for (int s = 0; s < 2; s++)
    begin
      if (a == 12'(pwmsq_pkg::OFS_SEQ0 + s * pwmsq_pkg::SEQ_STRIDE))
        rd_word = q.ptr[s];
      if (a == 12'(pwmsq_pkg::OFS_SEQ0 + s * pwmsq_pkg::SEQ_STRIDE + 4))
        rd_word[14:0] = q.cnt[s];
      if (a == 12'(pwmsq_pkg::OFS_SEQ0 + s * pwmsq_pkg::SEQ_STRIDE + 8))
        rd_word[23:0] = q.refr[s];
      if (a == 12'(pwmsq_pkg::OFS_SEQ0 + s * pwmsq_pkg::SEQ_STRIDE + 12))
        rd_word[23:0] = q.dly[s];
    end
    for (int c = 0; c < NCH; c++)
      if (a == 12'(pwmsq_pkg::OFS_PSEL0 + 4 * c))
        rd_word = q.psel[c];
    for (int e = 0; e < pwmsq_pkg::NUM_EV; e++)
      if (a == 12'(pwmsq_pkg::OFS_EVENT0 + 4 * e))
        rd_word[0] = q.evs[e];
  end

  always_comb
  begin
    d = q;
    d.ev = '0;
    d.restart = 1'b0;
    fin = 1'b0;
    go = 1'b0;
    stop_now = 1'b0;
    // bus: waitrequest drops for one cycle, one cycle after the request
    d.wreq = !((AVS_READ_IN || AVS_WRITE_IN) && q.wreq);
    if ((AVS_READ_IN || AVS_WRITE_IN) && q.wreq)
      d.rdata = rd_word;
    if (wr)
    begin
      case (a)
        pwmsq_pkg::OFS_ENABLE:  d.enable = wd[0];
        pwmsq_pkg::OFS_TOP:     d.top = wd[14:0];
        pwmsq_pkg::OFS_DECODER: d.manual = wd[pwmsq_pkg::DEC_MANUAL_BIT];
        pwmsq_pkg::OFS_LOOP:    d.loopcnt = wd[15:0];
        default: ;
      endcase
      for (int s = 0; s < 2; s++)
      begin
        if (a == 12'(pwmsq_pkg::OFS_SEQ0 + s * pwmsq_pkg::SEQ_STRIDE))
          d.ptr[s] = wd;
        if (a == 12'(pwmsq_pkg::OFS_SEQ0 + s * pwmsq_pkg::SEQ_STRIDE + 4))
          d.cnt[s] = wd[14:0];
        if (a == 12'(pwmsq_pkg::OFS_SEQ0 + s * pwmsq_pkg::SEQ_STRIDE + 8))
          d.refr[s] = wd[23:0];
        if (a == 12'(pwmsq_pkg::OFS_SEQ0 + s * pwmsq_pkg::SEQ_STRIDE + 12))
          d.dly[s] = wd[23:0];
      end
      for (int c = 0; c < NCH; c++)
        if (a == 12'(pwmsq_pkg::OFS_PSEL0 + 4 * c))
          d.psel[c] = wd;
      for (int e = 0; e < pwmsq_pkg::NUM_EV; e++)
        if (a == 12'(pwmsq_pkg::OFS_EVENT0 + 4 * e))
          d.evs[e] = 1'b0;
    end
    // value fetch, one outstanding request
    if (q.req && RAM_ACK_IN)
    begin
      d.req = 1'b0;
      d.disc = 1'b0;
      if (!q.disc)
      begin
        d.nxt = RAM_DATA_IN;
        d.nxt_vld = 1'b1;
      end
    end
    else if (!q.req && !q.nxt_vld && want)
    begin
      d.req = 1'b1;
      d.addr = q.ptr[q.seq] + {16'h0000, fidx, 1'b0}; // RULE5
    end
    if (pe_w && q.run)
      d.ev[pwmsq_pkg::EV_PERIOD] = 1'b1;
    case (q.st)
      pwmsq_pkg::ST_LOAD:
        if (q.nxt_vld)
        begin
          d.cmp = q.nxt;
          d.nxt_vld = 1'b0;
          d.idx = 15'h0000;
          d.rcnt = q.refr[q.seq]; // RULE5
          d.st = pwmsq_pkg::ST_PLAY;
          d.run = 1'b1;
          d.restart = 1'b1;
          d.ev[q.seq ? pwmsq_pkg::EV_BEGUN1 : pwmsq_pkg::EV_BEGUN0] = 1'b1;
          if (q.cnt[q.seq] == 15'h0001)
            d.ev[q.seq ? pwmsq_pkg::EV_END1 : pwmsq_pkg::EV_END0] = 1'b1;
        end
      pwmsq_pkg::ST_PLAY:
        if (pe_w)
        begin
          if (!q.manual && q.rcnt != 24'h000000)
            d.rcnt = q.rcnt - 24'h000001; // RULE7
          if (adv && lastv)
            fin = 1'b1;
          else if (adv && q.nxt_vld)
          begin
            d.cmp = q.nxt; // RULE10
            d.nxt_vld = 1'b0;
            d.idx = q.idx + 15'h0001;
            d.rcnt = q.refr[q.seq];
            d.step_pend = 1'b0;
            if (nlast)
              d.ev[q.seq ? pwmsq_pkg::EV_END1 : pwmsq_pkg::EV_END0] = 1'b1;
          end
          // a late fetch leaves cmp as it was for another period RULE13
        end
      pwmsq_pkg::ST_DELAY:
        if (pe_w)
        begin
          if (q.dcnt <= 24'h000001)
            go = 1'b1;
          else
            d.dcnt = q.dcnt - 24'h000001; // RULE8
        end
      pwmsq_pkg::ST_HOLD: ; // RULE1
      default: ;
    endcase
    if (fin)
    begin
      d.step_pend = 1'b0;
      if (q.loops == 16'h0000)
        d.st = pwmsq_pkg::ST_HOLD; // RULE11
      else if (q.dly[q.seq] == 24'h000000)
        go = 1'b1; // RULE8
      else
      begin
        d.st = pwmsq_pkg::ST_DELAY; // RULE4
        d.dcnt = q.dly[q.seq];
      end
    end
    if (go)
    begin
      if (!q.seq)
      begin
        d.seq = 1'b1; // RULE2 RULE6
        d.st = pwmsq_pkg::ST_LOAD;
      end
      else if (q.loops == 16'h0001)
      begin
        d.loops = 16'h0000; // RULE9 RULE20
        d.ev[pwmsq_pkg::EV_LOOPS] = 1'b1;
        d.st = pwmsq_pkg::ST_HOLD;
      end
      else
      begin
        d.loops = q.loops - 16'h0001; // RULE6
        d.seq = 1'b0;
        d.st = pwmsq_pkg::ST_LOAD;
      end
    end
    if (q.stop_pend && (pe_w || !q.run))
    begin
      stop_now = 1'b1;
      d.run = 1'b0; // RULE19
      d.st = pwmsq_pkg::ST_IDLE;
      d.stop_pend = 1'b0;
      d.nxt_vld = 1'b0;
      d.disc = d.req;
      d.ev[pwmsq_pkg::EV_STOPPED] = 1'b1;
    end
    if (stop_t)
      d.stop_pend = 1'b1;
    if (step_t && q.manual)
      d.step_pend = 1'b1;
    for (int s = 0; s < 2; s++)
      if (start_t[s] && q.enable)
      begin
        d.st = pwmsq_pkg::ST_LOAD; // RULE3
        d.seq = 1'(s);
        d.loops = q.loopcnt;
        d.nxt_vld = 1'b0;
        d.stop_pend = 1'b0;
        d.step_pend = 1'b0;
        d.disc = d.req;
      end
    if (!q.enable)
    begin
      d.run = 1'b0;
      d.st = pwmsq_pkg::ST_IDLE;
      d.stop_pend = 1'b0;
    end
    // hardware set beats software clear
    d.evs = d.evs | d.ev;
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RESET_IN)
    begin
      q <= '0;
      q.wreq <= pwmsq_pkg::WREQ_RST;
      q.top <= pwmsq_pkg::TOP_RST;
      q.psel <= {NCH{pwmsq_pkg::PSEL_RST}};
    end
    else
      q <= d;
  end

  pwmsq_period_timer u_timer (
    .clk_in         (MCLK_IN),
    .rst_in         (RESET_IN),
    .run_in         (q.run && q.enable),
    .restart_in     (q.restart),
    .top_in         (q.top),
    .cnt_out        (cnt_w),
    .period_end_out (pe_w)
  );

  pwmsq_pin_route #(
    .NCH  (NCH),
    .NPIN (NPIN)
  ) u_route (
    .clk_in     (MCLK_IN),
    .rst_in     (RESET_IN),
    .drive_in   (q.run && q.enable),
    .cnt_in     (cnt_w),
    .duty_in    (q.cmp),
    .psel_in    (q.psel),
    .pin_out    (PIN_OUT),
    .pin_oe_out (PIN_OE_OUT)
  );

  assign AVS_READDATA_OUT         = q.rdata;
  assign AVS_WAITREQUEST_OUT      = q.wreq;
  assign RAM_REQ_OUT              = q.req;
  assign RAM_ADDR_OUT             = q.addr;
  assign STOPPED_EVENT_OUT        = q.ev[pwmsq_pkg::EV_STOPPED];
  assign SEQUENCE_BEGUN_EVENT_OUT = q.ev[pwmsq_pkg::EV_BEGUN1:pwmsq_pkg::EV_BEGUN0];
  assign SEQUENCE_END_EVENT_OUT   = q.ev[pwmsq_pkg::EV_END1:pwmsq_pkg::EV_END0];
  assign PERIOD_END_EVENT_OUT     = q.ev[pwmsq_pkg::EV_PERIOD];
  assign LOOPS_COMPLETE_EVENT_OUT = q.ev[pwmsq_pkg::EV_LOOPS];

  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RESET_IN);

  chk_hold_keeps_value: assert property ( // RULE1
    q.st == pwmsq_pkg::ST_HOLD && !start_any |=> $stable(q.cmp))
    else $error("held value changed after loops complete");
  chk_chain_to_seq1: assert property ( // RULE2
    go && !q.seq && !stop_now && !start_any && q.enable
    |=> q.st == pwmsq_pkg::ST_LOAD && q.seq)
    else $error("sequence 1 did not follow sequence 0");
  chk_start_picks_seq: assert property ( // RULE3
    start_t[1] && q.enable |=> q.st == pwmsq_pkg::ST_LOAD && q.seq == 1'b1)
    else $error("start did not select sequence 1");
  chk_loops_end_seq1: assert property ( // RULE4
    q.ev[pwmsq_pkg::EV_LOOPS] |-> q.seq && q.loops == 16'h0000)
    else $error("loops complete outside sequence 1 end");
  chk_fetch_address: assert property ( // RULE5
    $rose(q.req) && !q.disc && q.st != pwmsq_pkg::ST_IDLE
    |-> q.addr == q.ptr[q.seq] + {16'h0000, fidx, 1'b0})
    else $error("fetch address wrong");
  chk_refresh_hold: assert property ( // RULE7
    pe_w && q.st == pwmsq_pkg::ST_PLAY && !q.manual && q.rcnt != 24'h000000
    && !q.stop_pend && !start_any && q.enable
    |=> $stable(q.cmp) && q.rcnt == $past(q.rcnt) - 24'h000001)
    else $error("value not held for refresh periods");
  chk_delay_counts: assert property ( // RULE8
    pe_w && q.st == pwmsq_pkg::ST_DELAY && q.dcnt > 24'h000001
    && !q.stop_pend && !start_any && q.enable
    |=> q.st == pwmsq_pkg::ST_DELAY && q.dcnt == $past(q.dcnt) - 24'h000001)
    else $error("end delay miscounted");
  chk_manual_waits: assert property ( // RULE10
    q.st == pwmsq_pkg::ST_PLAY && q.manual && !q.step_pend |=> $stable(q.cmp))
    else $error("manual mode advanced without step");
  chk_single_shot: assert property ( // RULE11
    fin && q.loops == 16'h0000 && !stop_now && !start_any && q.enable
    |=> q.st == pwmsq_pkg::ST_HOLD)
    else $error("single shot did not stop");
  chk_late_fetch: assert property ( // RULE13
    pe_w && q.st == pwmsq_pkg::ST_PLAY && adv && !lastv && !q.nxt_vld |=> $stable(q.cmp))
    else $error("compare changed without fetched value");
  chk_stop_at_period: assert property ( // RULE19
    q.stop_pend && q.run && pe_w && !start_any
    |=> !q.run && q.ev[pwmsq_pkg::EV_STOPPED])
    else $error("stop not taken at period end");
  chk_loops_once: assert property ( // RULE20
    q.ev[pwmsq_pkg::EV_LOOPS] |=> !q.ev[pwmsq_pkg::EV_LOOPS] [*3])
    else $error("loops complete raised twice");

  cov_loops_done: cover property (q.ev[pwmsq_pkg::EV_LOOPS]);
  cov_stopped: cover property (q.ev[pwmsq_pkg::EV_STOPPED] && $past(q.run));
  cov_begun_seq1: cover property (q.ev[pwmsq_pkg::EV_BEGUN1]);
  cov_manual_step: cover property (q.st == pwmsq_pkg::ST_PLAY && q.manual && q.step_pend && pe_w);
endmodule : pwmsq_playback
`default_nettype wire

// [shared/pwmsq_pkg.sv]
`default_nettype none
package pwmsq_pkg;
  localparam logic [11:0] OFS_STOP    = 12'h004;
  localparam logic [11:0] OFS_START0  = 12'h008;
  localparam logic [11:0] OFS_START1  = 12'h00c;
  localparam logic [11:0] OFS_STEP    = 12'h010;
  localparam logic [11:0] OFS_EVENT0  = 12'h104;
  localparam logic [11:0] OFS_ENABLE  = 12'h500;
  localparam logic [11:0] OFS_TOP     = 12'h508;
  localparam logic [11:0] OFS_DECODER = 12'h510;
  localparam logic [11:0] OFS_LOOP    = 12'h514;
  localparam logic [11:0] OFS_SEQ0    = 12'h520;
  localparam logic [11:0] SEQ_STRIDE  = 12'h020;
  localparam logic [11:0] OFS_PSEL0   = 12'h560;
  localparam logic [11:0] OFS_STATUS  = 12'h600;

  localparam int NUM_EV     = 7;
  localparam int EV_STOPPED = 0;
  localparam int EV_BEGUN0  = 1;
  localparam int EV_BEGUN1  = 2;
  localparam int EV_END0    = 3;
  localparam int EV_END1    = 4;
  localparam int EV_PERIOD  = 5;
  localparam int EV_LOOPS   = 6;

  localparam int DEC_MANUAL_BIT = 8;
  localparam int PSEL_DISC_BIT  = 31;
  localparam int PSEL_PIN_W     = 5;

  localparam logic [14:0] TOP_RST  = 15'h03e8;
  localparam logic [31:0] PSEL_RST = 32'hffffffff;
  localparam logic        WREQ_RST = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_PLAY  = 3'b010,
    ST_DELAY = 3'b011,
    ST_HOLD  = 3'b100
  } pwmsq_state_e;
endpackage : pwmsq_pkg
`default_nettype wire

// [logic/pwmsq_period_timer.sv]
`timescale 1ns/1ns
`default_nettype none
module pwmsq_period_timer (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        run_in,
  input  wire logic        restart_in,
  input  wire logic [14:0] top_in,
  output logic      [14:0] cnt_out,
  output logic             period_end_out
);
  typedef struct packed {
    logic [14:0] cnt;
    logic        pe;
  } pwmsq_timer_s;

  pwmsq_timer_s q;
  pwmsq_timer_s d;
  logic [14:0]  lim;

  assign lim = (top_in == 15'h0000) ? 15'h0000 : top_in - 15'h0001;

  always_comb
  begin
    d = q;
    d.pe = 1'b0;
    if (!run_in || restart_in)
      d.cnt = 15'h0000;
    else if (q.cnt >= lim)
    begin
      d.cnt = 15'h0000;
      d.pe = 1'b1;
    end
    else
      d.cnt = q.cnt + 15'h0001;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      q <= '0;
    else
      q <= d;
  end

  assign cnt_out        = q.cnt;
  assign period_end_out = q.pe;
endmodule : pwmsq_period_timer
`default_nettype wire

// [logic/pwmsq_pin_route.sv]
`timescale 1ns/1ns
`default_nettype none
module pwmsq_pin_route #(
  parameter int NCH  = 4,
  parameter int NPIN = 32
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              drive_in,
  input  wire logic [14:0]       cnt_in,
  input  wire logic [15:0]       duty_in,
  input  wire logic [NCH*32-1:0] psel_in,
  output logic      [NPIN-1:0]   pin_out,
  output logic      [NPIN-1:0]   pin_oe_out
);
  typedef struct packed {
    logic [NPIN-1:0] pin;
    logic [NPIN-1:0] oe;
  } pwmsq_route_s;

  pwmsq_route_s                              q;
  pwmsq_route_s                              d;
  logic                                      lvl;
  logic [NCH-1:0]                            con;
  logic [NCH-1:0][pwmsq_pkg::PSEL_PIN_W-1:0] sel;

  // bit 15 of the duty word inverts the polarity
  assign lvl = (cnt_in < duty_in[14:0]) ^ duty_in[15];

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      assign con[g] = !psel_in[g*32 + pwmsq_pkg::PSEL_DISC_BIT];
      assign sel[g] = psel_in[g*32 +: pwmsq_pkg::PSEL_PIN_W];
    end
  endgenerate

  always_comb
  begin
    d.pin = '0;
    d.oe  = '0;
    for (int p = 0; p < NPIN; p++)
      for (int c = 0; c < NCH; c++)
        if (drive_in && con[c] && sel[c] == pwmsq_pkg::PSEL_PIN_W'(p)) // RULE14 RULE15
        begin
          d.oe[p]  = 1'b1;
          d.pin[p] = lvl;
        end
  end

  // released pins fall back to the gpio idle level
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      q <= '0;
    else
      q <= d; // RULE17
  end

  assign pin_out    = q.pin;
  assign pin_oe_out = q.oe;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  chk_idle_release: assert property (!drive_in |=> pin_oe_out == '0) // RULE15
    else $error("pin still driven while generation is off");
  chk_disc_no_pin: assert property (con == '0 |=> pin_oe_out == '0) // RULE14
    else $error("disconnected channel drives a pin");
endmodule : pwmsq_pin_route
`default_nettype wire

// [tb/pwmsq_ram_model.sv]
`timescale 1ns/1ns
`default_nettype none
module pwmsq_ram_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        slow_in,
  input  wire logic        req_in,
  input  wire logic [31:0] addr_in,
  output logic             ack_out,
  output logic      [15:0] data_out
);
  logic [2:0] wait_q;
  logic       tog_q;
  // duty from address; bus shows junk outside the ack cycle
  assign data_out = ack_out ? {1'b0, addr_in[15:1]} : {16{tog_q}};
  always_ff @(posedge clk_in)
  begin
    tog_q <= rst_in ? 1'b0 : ~tog_q;
    if (rst_in || !req_in || ack_out)
    begin
      ack_out <= 1'b0;
      wait_q  <= 3'h0;
    end
    else if (wait_q == (slow_in ? 3'h5 : 3'h0))
      ack_out <= 1'b1;
    else
      wait_q <= wait_q + 3'h1;
  end
endmodule : pwmsq_ram_model
`default_nettype wire

// [tb/pwmsq_playback_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module pwmsq_playback_tb;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} pwmsq_row_s;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        slow = 1'b0;
  logic [3:0]  be = 4'hf;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, radr, pin, oe, q, a_first;
  logic [15:0] rdata;
  logic [1:0]  beg, fin;
  logic        wreq, req, ack, stp, per, lps;
  logic [6:0]  ev;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          got_a = 0;
  int          n_ev [7];
  int          t_ev [7];
  int          gap = 0;
  logic [31:0] pad;
  logic [31:0] gpio_out = 32'h0;
  pwmsq_row_s  rows [7] = '{'{12'h508, 32'hffffffff, 32'h7fff}, '{12'h514, 32'hffffffff, 32'hffff},
    '{12'h524, 32'hffffffff, 32'h7fff}, '{12'h528, 32'hffffffff, 32'hffffff},
    '{12'h52c, 32'hffffffff, 32'hffffff}, '{12'h700, 32'hffffffff, 32'h0},
    '{12'h564, 32'h8000001f, 32'h8000001f}};
  // top 16, channel 0 on pin 5, seq0 two values, seq1 one value
  logic [11:0] ca [11] = '{12'h508, 12'h560, 12'h520, 12'h524, 12'h528, 12'h52c,
    12'h540, 12'h544, 12'h548, 12'h54c, 12'h500};
  logic [31:0] cd [11] = '{32'h10, 32'h5, 32'h1000, 32'h2, 32'h1, 32'h1,
    32'h2000, 32'h1, 32'h0, 32'h2, 32'h1};
  assign ev = {lps, per, fin, beg, stp};
  // board level: gpio idle value wherever the block lets go
  assign pad = (oe & pin) | (~oe & gpio_out);
  always #5 clk = ~clk;
  pwmsq_playback pwmsq_playback_i (.MCLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(adr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq), .RAM_REQ_OUT(req),
    .RAM_ADDR_OUT(radr), .RAM_ACK_IN(ack), .RAM_DATA_IN(rdata), .PIN_OUT(pin),
    .PIN_OE_OUT(oe), .STOPPED_EVENT_OUT(stp), .SEQUENCE_BEGUN_EVENT_OUT(beg),
    .SEQUENCE_END_EVENT_OUT(fin), .PERIOD_END_EVENT_OUT(per), .LOOPS_COMPLETE_EVENT_OUT(lps));
  pwmsq_ram_model pwmsq_ram_model_i (.clk_in(clk), .rst_in(rst), .slow_in(slow),
    .req_in(req), .addr_in(radr), .ack_out(ack), .data_out(rdata));
  task automatic give_verdict();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0)
      @(posedge clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic clr();
    got_a = 0;
    for (int k = 0; k < 7; k++)
      n_ev[k] = 0;
  endtask : clr
  task automatic play(input logic [31:0] loops, input logic [11:0] go);
    bus(1'b1, pwmsq_pkg::OFS_LOOP, loops);
    clr();
    bus(1'b1, go, 32'h1);
  endtask : play
  task automatic halt();
    clr();
    bus(1'b1, pwmsq_pkg::OFS_STOP, 32'h1);
    wait (n_ev[0] == 1);
    repeat (3) @(posedge clk);
    chk(oe, 32'h0);
    chk(pad, gpio_out);
  endtask : halt
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    for (int k = 0; k < 7; k++)
      if (ev[k] === 1'b1)
      begin
        if (k == 5)
          gap = cyc - t_ev[5];
        t_ev[k] = cyc;
        n_ev[k]++;
      end
    if (req === 1'b1 && got_a == 0)
    begin
      a_first = radr;
      got_a = 1;
    end
    if (cyc == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial
  begin
    clr();
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, pwmsq_pkg::OFS_TOP, 32'h0);
    chk(q, 32'h3e8);
    bus(1'b0, pwmsq_pkg::OFS_PSEL0, 32'h0);
    chk(q, 32'hffffffff);
    chk(oe, 32'h0);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk(q, rows[i].e);
    end
    be <= 4'h3;
    bus(1'b1, pwmsq_pkg::OFS_TOP, 32'h0);
    be <= 4'hf;
    bus(1'b0, pwmsq_pkg::OFS_TOP, 32'h0);
    chk(q, 32'h7fff);
    foreach (ca[i])
      bus(1'b1, ca[i], cd[i]);
    play(32'h1, pwmsq_pkg::OFS_START0);
    wait (n_ev[6] == 1);
    repeat (200) @(posedge clk);
    chk(n_ev[2], 1);
    chk(n_ev[4], 1);
    chk(n_ev[6], 1);
    chk(a_first, 32'h1000);
    chk({31'h0, (t_ev[3] - t_ev[1]) inside {[30:40]}}, 32'h1);
    chk({31'h0, (t_ev[2] - t_ev[3]) inside {[46:60]}}, 32'h1);
    chk({31'h0, t_ev[6] - t_ev[4] >= 46}, 32'h1);
    chk(n_ev[1], 1);
    chk(oe, 32'h20);
    halt();
    slow <= 1'b1;
    play(32'h2, pwmsq_pkg::OFS_START1);
    wait (n_ev[6] == 1);
    repeat (100) @(posedge clk);
    chk(n_ev[2], 2);
    chk(n_ev[1], 1);
    chk(n_ev[4], 2);
    chk(n_ev[6], 1);
    chk(a_first, 32'h2000);
    halt();
    slow <= 1'b0;
    play(32'h0, pwmsq_pkg::OFS_START1);
    wait (n_ev[4] == 1);
    repeat (100) @(posedge clk);
    chk(n_ev[1] + n_ev[6], 0);
    chk(oe, 32'h20);
    chk({31'h0, pin[5]}, 32'h1);
    chk(gap, 16);
    halt();
    bus(1'b1, pwmsq_pkg::OFS_DECODER, 32'h100);
    play(32'h0, pwmsq_pkg::OFS_START0);
    wait (n_ev[1] == 1);
    repeat (80) @(posedge clk);
    chk(n_ev[3], 0);
    bus(1'b1, pwmsq_pkg::OFS_STEP, 32'h1);
    repeat (40) @(posedge clk);
    chk(n_ev[3], 1);
    halt();
    // period of 4 cycles, slow fetch: second value misses its period
    slow <= 1'b1;
    bus(1'b1, pwmsq_pkg::OFS_DECODER, 32'h0);
    bus(1'b1, 12'h528, 32'h0);
    bus(1'b1, pwmsq_pkg::OFS_TOP, 32'h4);
    play(32'h0, pwmsq_pkg::OFS_START0);
    wait (n_ev[3] == 1);
    chk(t_ev[3] - t_ev[1], 32'ha);
    halt();
    give_verdict();
  end
endmodule : pwmsq_playback_tb
`default_nettype wire
